// ---- design/qspi_seq_pkg.sv ----
`default_nettype none
package qspi_seq_pkg;
  // buffers
  localparam int FIFO_DEPTH = 32;
  localparam int HALF_DEPTH = 16;
  localparam int PTR_W      = 5;
  localparam int CNT_W      = 6;
  // control_reg layout and reset value
  localparam int         CTRL_ENABLE_BIT = 6;
  localparam int         CTRL_MASTER_BIT = 3;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  // buffer_control_reg layout and reset value
  localparam int         TX_RST_BIT  = 7;
  localparam int         RX_RST_BIT  = 6;
  localparam int         TX_TRIG_LSB = 4;
  localparam int         RX_TRIG_LSB = 0;
  localparam logic [7:0] BFCR_RESET  = 8'h00;
  // command slot layout
  localparam int DIR_BIT   = 0;
  localparam int MODE_LSB  = 1;
  localparam int KEEP_BIT  = 3;
  localparam int UNIT_LSB  = 4;
  localparam logic [3:0] UNIT_8  = 4'h0;
  localparam logic [3:0] UNIT_16 = 4'h1;
  localparam logic [3:0] UNIT_32 = 4'h2;
  // sequence
  localparam logic [1:0] SEQ_LEN_RESET = 2'h0;
  localparam logic [1:0] SEQ_LAST_SLOT = 2'h2;
  // serial clock half period
  localparam int         REF_PERIOD_NS = 50;
  localparam int         SCK_HALF_NS   = 200;
  localparam int         SCK_HALF_CYC  = (SCK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [2:0] DIV_LAST      = 3'(SCK_HALF_CYC - 1);

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2
  } lane_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_SELECT   = 3'h1,
    ST_LOAD     = 3'h2,
    ST_SHIFT    = 3'h3,
    ST_SLOT_END = 3'h4
  } state_t;
endpackage
`default_nettype wire

// ---- design/qspi_seq_master.sv ----
// Operation
// - lane mode 01 dual, 10 quad
// - direction bit 1 reads, 0 writes
// - keep bit 1 holds select after slot
// - keep bit 0 negates select after slot
// - sequence length chooses how many slots run
// - control 48h enables master, clock driven
// - control 08h disables, keeps master, clock
// - buffer control resets both buffers, releases
// - two 32-byte buffers, half is 16
// - buffer control 1Dh sets triggers 16/16
// - buffer control 30h sets triggers 0/1
// - unit field 0010 32-bit, 0000 8-bit
// - lane mode 00 selects single lane
`default_nettype none
module qspi_seq_master (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // control
  input  wire logic                 ctrl_write,
  input  wire logic [7:0]           ctrl_wdata,
  input  wire logic                 bfcr_write,
  input  wire logic [7:0]           bfcr_wdata,
  input  wire logic [1:0]           sequence_length_reg,
  input  wire logic [7:0]           seq_command_slot0,
  input  wire logic [7:0]           seq_command_slot1,
  input  wire logic [7:0]           seq_command_slot2,
  input  wire logic [7:0]           slot0_multiplier,
  input  wire logic [7:0]           slot1_multiplier,
  input  wire logic [7:0]           slot2_multiplier,
  input  wire logic                 seq_start,
  input  wire logic                 clr_select_negated,
  input  wire logic                 clr_tx_empty,
  input  wire logic                 clr_rx_full,
  // status
  output logic [7:0]                control_reg,
  output logic [7:0]                buffer_control_reg,
  output logic                      select_negated_flag,
  output logic                      tx_empty_flag,
  output logic                      rx_full_flag,
  output logic                      busy,
  // transmit data
  input  wire logic                 tx_valid,
  input  wire logic [7:0]           tx_data,
  output logic                      tx_ready,
  // receive data
  output logic                      rx_valid,
  output logic [7:0]                rx_data,
  input  wire logic                 rx_ready,
  // serial pins
  output logic                      serial_clock_pin,
  output logic                      serial_clock_oe,
  output logic                      slave_select_line_n,
  input  wire logic [3:0]           io_in,
  output logic [3:0]                io_out,
  output logic [3:0]                io_oe
);
  import qspi_seq_pkg::*;

  function automatic logic [5:0] tx_trig(input logic [1:0] code);
    case (code)
      2'h0:    tx_trig = 6'h18;
      2'h1:    tx_trig = 6'h10;
      2'h2:    tx_trig = 6'h08;
      default: tx_trig = 6'h00;
    endcase
  endfunction

  function automatic logic [5:0] rx_trig(input logic [2:0] code);
    case (code)
      3'h0:    rx_trig = 6'h01;
      3'h1:    rx_trig = 6'h02;
      3'h2:    rx_trig = 6'h04;
      3'h3:    rx_trig = 6'h08;
      3'h4:    rx_trig = 6'h0c;
      3'h5:    rx_trig = 6'h10;
      3'h6:    rx_trig = 6'h14;
      default: rx_trig = 6'h18;
    endcase
  endfunction

  // unit bytes times multiplier; a zero multiplier runs 256 units
  function automatic logic [10:0] slot_bytes(input logic [3:0] unit, input logic [7:0] mult);
    logic [10:0] m;
    m = (mult == 8'h00) ? 11'h100 : {3'h0, mult};
    case (unit)
      UNIT_32: slot_bytes = 11'(m << 2);
      UNIT_16: slot_bytes = 11'(m << 1);
      default: slot_bytes = m;
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input logic [1:0] mode);
    case (mode)
      LANE_DUAL: lane_mask = 4'h3;
      LANE_QUAD: lane_mask = 4'hf;
      default:   lane_mask = 4'h1;
    endcase
  endfunction

  function automatic logic [2:0] last_grp(input logic [1:0] mode);
    case (mode)
      LANE_DUAL: last_grp = 3'h3;
      LANE_QUAD: last_grp = 3'h1;
      default:   last_grp = 3'h7;
    endcase
  endfunction

  // shifts msb first; reads take new bits in at the bottom
  function automatic logic [7:0] shift_step(input logic [7:0] sh, input logic [1:0] mode, input logic [3:0] din);
    case (mode)
      LANE_DUAL: shift_step = {sh[5:0], din[1:0]};
      LANE_QUAD: shift_step = {sh[3:0], din};
      default:   shift_step = {sh[6:0], din[1]};
    endcase
  endfunction

  function automatic logic [3:0] lane_out(input logic [7:0] sh, input logic [1:0] mode);
    case (mode)
      LANE_DUAL: lane_out = {2'h0, sh[7:6]};
      LANE_QUAD: lane_out = sh[7:4];
      default:   lane_out = {3'h0, sh[7]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_t       state, next_state;
  logic [2:0]   div_cnt, next_div_cnt, grp, next_grp;
  logic [1:0]   slot, next_slot, mode, next_mode;
  logic         dir, next_dir, keep, next_keep;
  logic [10:0]  bytes_left, next_bytes_left;
  logic [7:0]   shreg, next_shreg, cmd;
  logic [7:0]   next_ctrl, next_bfcr, mult;
  logic         next_sck, next_sel_n, next_neg_f, next_txe_f, next_rxf_f;
  logic [3:0]   next_io_out, next_io_oe, sync1, sync2;
  logic [1:0]   last_slot;
  logic         tick, enabled, tx_pop, rx_push, neg_evt;
  logic [7:0]   tx_mem [FIFO_DEPTH];
  logic [7:0]   rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wr, tx_rd, rx_wr, rx_rd, next_tx_wr, next_tx_rd, next_rx_wr, next_rx_rd;
  logic [CNT_W-1:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
  logic         tx_push, rx_move, rx_pop, next_tx_ready, next_rx_valid;
  logic [1:0]   ob_cnt, next_ob_cnt;
  logic [7:0]   ob1, next_ob0, next_ob1;

  assign enabled   = control_reg[CTRL_ENABLE_BIT];
  assign tick      = (div_cnt == DIV_LAST);
  assign last_slot = (sequence_length_reg > SEQ_LAST_SLOT) ? SEQ_LAST_SLOT : sequence_length_reg;
  assign cmd       = (slot == 2'h0) ? seq_command_slot0 : (slot == 2'h1) ? seq_command_slot1 : seq_command_slot2;
  assign mult      = (slot == 2'h0) ? slot0_multiplier : (slot == 2'h1) ? slot1_multiplier : slot2_multiplier;

  // pin inputs pass two flops; only the second is read
  always_ff @(posedge ref_clk) begin
    sync1 <= io_in;
    sync2 <= sync1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence engine
  always_comb begin
    next_state      = state;
    next_div_cnt    = tick ? 3'h0 : 3'(div_cnt + 3'h1);
    next_grp        = grp;
    next_slot       = slot;
    next_mode       = mode;
    next_dir        = dir;
    next_keep       = keep;
    next_bytes_left = bytes_left;
    next_shreg      = shreg;
    next_sck        = serial_clock_pin;
    next_sel_n      = slave_select_line_n;
    tx_pop          = 1'b0;
    rx_push         = 1'b0;
    neg_evt         = 1'b0;
    if (!enabled) begin
      // disable drops any transfer in flight; master bit stays in control_reg
      next_state = ST_IDLE;
      next_sck   = 1'b0;
      next_sel_n = 1'b1;
      neg_evt    = !slave_select_line_n;
    end else begin
      case (state)
        ST_IDLE: begin
          if (seq_start) begin
            next_slot  = 2'h0;
            next_state = ST_SELECT;
          end
        end
        ST_SELECT: begin
          next_dir        = cmd[DIR_BIT];
          next_mode       = cmd[MODE_LSB +: 2];
          next_keep       = cmd[KEEP_BIT];
          next_bytes_left = slot_bytes(cmd[UNIT_LSB +: 4], mult);
          next_sel_n      = 1'b0;
          // leave on a divider tick so the first read sample sees data from after select fell
          next_state      = tick ? ST_LOAD : ST_SELECT;
        end
        ST_LOAD: begin
          // stall rather than underrun the transmit or overrun the receive buffer
          next_grp = 3'h0;
          if (!dir && tx_cnt != '0) begin
            tx_pop     = 1'b1;
            next_shreg = tx_mem[tx_rd];
            next_state = ST_SHIFT;
          end else if (dir && rx_cnt != CNT_W'(FIFO_DEPTH)) begin
            next_shreg = 8'h00;
            next_state = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            next_sck = !serial_clock_pin;
            if (!serial_clock_pin) begin
              if (dir) next_shreg = shift_step(shreg, mode, sync2);
            end else begin
              if (!dir) next_shreg = shift_step(shreg, mode, 4'h0);
              next_grp = 3'(grp + 3'h1);
              if (grp == last_grp(mode)) begin
                rx_push         = dir;
                next_bytes_left = 11'(bytes_left - 11'h1);
                next_state      = (bytes_left == 11'h1) ? ST_SLOT_END : ST_LOAD;
              end
            end
          end
        end
        ST_SLOT_END: begin
          if (!keep) begin
            next_sel_n = 1'b1;
            neg_evt    = 1'b1;
          end
          // with keep set the select stays low into the next slot or access
          if (slot == last_slot) begin
            next_state = ST_IDLE;
          end else begin
            next_slot  = 2'(slot + 2'h1);
            next_state = ST_SELECT;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    next_io_oe  = (next_state == ST_SHIFT && !next_dir) ? lane_mask(next_mode) : 4'h0;
    next_io_out = lane_out(next_shreg, next_mode);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state               <= ST_IDLE;
      div_cnt             <= 3'h0;
      grp                 <= 3'h0;
      slot                <= 2'h0;
      mode                <= LANE_SINGLE;
      dir                 <= 1'b0;
      keep                <= 1'b0;
      bytes_left          <= 11'h0;
      shreg               <= 8'h00;
      serial_clock_pin    <= 1'b0;
      slave_select_line_n <= 1'b1;
      io_out              <= 4'h0;
      io_oe               <= 4'h0;
      busy                <= 1'b0;
    end else begin
      state               <= next_state;
      div_cnt             <= next_div_cnt;
      grp                 <= next_grp;
      slot                <= next_slot;
      mode                <= next_mode;
      dir                 <= next_dir;
      keep                <= next_keep;
      bytes_left          <= next_bytes_left;
      shreg               <= next_shreg;
      serial_clock_pin    <= next_sck;
      slave_select_line_n <= next_sel_n;
      io_out              <= next_io_out;
      io_oe               <= next_io_oe;
      busy                <= (next_state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, flags and buffers
  assign tx_push = tx_valid && tx_ready;
  assign rx_pop  = rx_valid && rx_ready;
  assign rx_move = (rx_cnt != '0) && (ob_cnt != 2'h2 || rx_pop);

  always_comb begin
    next_ctrl   = ctrl_write ? ctrl_wdata : control_reg;
    next_bfcr   = bfcr_write ? bfcr_wdata : buffer_control_reg;
    next_tx_wr  = PTR_W'(tx_wr + {4'h0, tx_push});
    next_tx_rd  = PTR_W'(tx_rd + {4'h0, tx_pop});
    next_tx_cnt = CNT_W'(tx_cnt + {5'h0, tx_push} - {5'h0, tx_pop});
    next_rx_wr  = PTR_W'(rx_wr + {4'h0, rx_push});
    next_rx_rd  = PTR_W'(rx_rd + {4'h0, rx_move});
    next_rx_cnt = CNT_W'(rx_cnt + {5'h0, rx_push} - {5'h0, rx_move});
    next_ob0    = rx_data;
    next_ob1    = ob1;
    next_ob_cnt = ob_cnt;
    if (rx_pop) begin
      next_ob0    = ob1;
      next_ob_cnt = 2'(next_ob_cnt - 2'h1);
    end
    if (rx_move) begin
      if (next_ob_cnt == 2'h0) next_ob0 = rx_mem[rx_rd];
      else next_ob1 = rx_mem[rx_rd];
      next_ob_cnt = 2'(next_ob_cnt + 2'h1);
    end
    // a reset bit holds its buffer empty until software writes it back to zero
    if (buffer_control_reg[TX_RST_BIT]) begin
      next_tx_wr  = '0;
      next_tx_rd  = '0;
      next_tx_cnt = '0;
    end
    if (buffer_control_reg[RX_RST_BIT]) begin
      next_rx_wr  = '0;
      next_rx_rd  = '0;
      next_rx_cnt = '0;
      next_ob_cnt = 2'h0;
    end
    next_tx_ready = (next_tx_cnt != CNT_W'(FIFO_DEPTH)) && !next_bfcr[TX_RST_BIT];
    next_rx_valid = (next_ob_cnt != 2'h0);
    // a set in the same cycle as its clear wins
    next_neg_f = neg_evt || (select_negated_flag && !clr_select_negated);
    next_txe_f = (tx_cnt <= tx_trig(buffer_control_reg[TX_TRIG_LSB +: 2])) || (tx_empty_flag && !clr_tx_empty);
    next_rxf_f = (rx_cnt >= rx_trig(buffer_control_reg[RX_TRIG_LSB +: 3])) || (rx_full_flag && !clr_rx_full);
  end

  always_ff @(posedge ref_clk) begin
    if (tx_push) tx_mem[tx_wr] <= tx_data;
    if (rx_push) rx_mem[rx_wr] <= shreg;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      control_reg         <= CTRL_RESET;
      buffer_control_reg  <= BFCR_RESET;
      serial_clock_oe     <= 1'b0;
      tx_wr               <= '0;
      tx_rd               <= '0;
      tx_cnt              <= '0;
      rx_wr               <= '0;
      rx_rd               <= '0;
      rx_cnt              <= '0;
      ob_cnt              <= 2'h0;
      ob1                 <= 8'h00;
      rx_data             <= 8'h00;
      rx_valid            <= 1'b0;
      tx_ready            <= 1'b0;
      select_negated_flag <= 1'b0;
      tx_empty_flag       <= 1'b0;
      rx_full_flag        <= 1'b0;
    end else begin
      control_reg         <= next_ctrl;
      buffer_control_reg  <= next_bfcr;
      serial_clock_oe     <= next_ctrl[CTRL_MASTER_BIT];
      tx_wr               <= next_tx_wr;
      tx_rd               <= next_tx_rd;
      tx_cnt              <= next_tx_cnt;
      rx_wr               <= next_rx_wr;
      rx_rd               <= next_rx_rd;
      rx_cnt              <= next_rx_cnt;
      ob_cnt              <= next_ob_cnt;
      ob1                 <= next_ob1;
      rx_data             <= next_ob0;
      rx_valid            <= next_rx_valid;
      tx_ready            <= next_tx_ready;
      select_negated_flag <= next_neg_f;
      tx_empty_flag       <= next_txe_f;
      rx_full_flag        <= next_rxf_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_dual_lane_oe: assert property (state == ST_SHIFT && !dir && mode == LANE_DUAL |-> io_oe == 4'h3)
    else $error("dual write must drive two lanes");
  chk_quad_lane_oe: assert property (state == ST_SHIFT && !dir && mode == LANE_QUAD |-> io_oe == 4'hf)
    else $error("quad write must drive four lanes");
  chk_single_lane_oe: assert property (state == ST_SHIFT && !dir && mode == LANE_SINGLE |-> io_oe == 4'h1)
    else $error("single write must drive one lane");
  chk_read_no_drive: assert property (state == ST_SHIFT && dir |-> io_oe == 4'h0)
    else $error("read step drives data lanes");
  chk_keep_select: assert property (state == ST_SLOT_END && keep && enabled |=> !slave_select_line_n)
    else $error("select released despite keep");
  chk_negate_select: assert property (state == ST_SLOT_END && !keep && enabled
                                      |=> slave_select_line_n && select_negated_flag)
    else $error("select not negated after slot");
  chk_slot_ascend: assert property (state == ST_SLOT_END && enabled && slot != last_slot
                                    |=> state == ST_SELECT && slot == 2'($past(slot) + 2'h1))
    else $error("slots out of order");
  chk_enable_48h: assert property (ctrl_write && ctrl_wdata == 8'h48 |=> enabled && serial_clock_oe)
    else $error("48h did not enable master");
  chk_disable_08h: assert property (ctrl_write && ctrl_wdata == 8'h08
                                    |=> ##1 state == ST_IDLE && slave_select_line_n && serial_clock_oe)
    else $error("08h did not disable");
  chk_buf_reset: assert property (buffer_control_reg[TX_RST_BIT] && buffer_control_reg[RX_RST_BIT]
                                  |=> tx_cnt == '0 && rx_cnt == '0 && !rx_valid)
    else $error("buffers not held empty");
  chk_buf_depth: assert property (tx_cnt <= 6'd32 && rx_cnt <= 6'd32)
    else $error("buffer count above 32");
  chk_trig_1dh_tx: assert property (buffer_control_reg == 8'h1d && tx_cnt <= 6'd16 |=> tx_empty_flag)
    else $error("1Dh transmit trigger wrong");
  chk_trig_1dh_rx: assert property (buffer_control_reg == 8'h1d && rx_cnt >= 6'd16 |=> rx_full_flag)
    else $error("1Dh receive trigger wrong");
  chk_trig_30h: assert property (buffer_control_reg == 8'h30 && tx_cnt == '0 && rx_cnt == 6'd1
                                 |=> tx_empty_flag && rx_full_flag)
    else $error("30h triggers wrong");
  chk_unit_32bit: assert property (state == ST_SELECT && enabled && cmd[UNIT_LSB +: 4] == 4'h2 && mult == 8'h04
                                   |=> bytes_left == 11'd16)
    else $error("32-bit unit length wrong");
endmodule
`default_nettype wire

// ---- dv/flash_model.sv ----
`default_nettype none
module flash_model (
  // serial pins
  input  wire logic       serial_clock_pin,
  input  wire logic       slave_select_line_n,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic [3:0]      io_in,
  // bench controls: lanes in use, read or write step
  input  wire logic [2:0] lanes,
  input  wire logic       rd_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rd_idx  = 8'h00;
  logic [3:0] bitpos  = 4'h0;
  logic [3:0] wr_bits = 4'h0;
  logic [7:0] wr_acc  = 8'h00;
  logic       took    = 1'b0;
  logic [7:0] cur;
  logic [3:0] lane_bits;
  logic [7:0] wr_q [$];
  always_comb begin
    cur = (8'h3c + rd_idx * 8'h11) << bitpos;
    case (lanes)
      3'h4:    lane_bits = cur[7:4];
      3'h2:    lane_bits = {2'h0, cur[7:6]};
      default: lane_bits = {2'h0, cur[7], 1'b0};
    endcase
  end
  // released lines show the inverse, so a stale sample cannot pass
  assign io_in = (!slave_select_line_n && rd_mode) ? lane_bits : ~lane_bits;
  // a new access restarts the read stream
  always @(negedge slave_select_line_n) begin
    rd_idx = 8'h00;
    bitpos = 4'h0;
    wr_bits = 4'h0;
    took = 1'b0;
  end
  always @(posedge serial_clock_pin) begin
    if (!slave_select_line_n && rd_mode)
      took = 1'b1;
    if (!slave_select_line_n && !rd_mode && io_oe[0]) begin
      wr_acc = (wr_acc << lanes) | 8'(io_out & ((4'h1 << lanes) - 4'h1));
      wr_bits = wr_bits + 4'(lanes);
      if (wr_bits == 4'h8) begin
        wr_q.push_back(wr_acc);
        wr_bits = 4'h0;
      end
    end
  end
  // data moves on the falling edge, as a mode 0 slave does
  always @(negedge serial_clock_pin) begin
    if (took) begin
      took = 1'b0;
      bitpos = bitpos + 4'(lanes);
      if (bitpos == 4'h8) begin
        bitpos = 4'h0;
        rd_idx = rd_idx + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
module tb_top;
  import qspi_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, nrst, ctrl_write, bfcr_write, seq_start, tx_valid, rx_ready, rd_mode;
  logic       clr_select_negated, clr_tx_empty, clr_rx_full;
  logic [7:0] ctrl_wdata, bfcr_wdata, tx_data, seq_command_slot0, seq_command_slot1, seq_command_slot2;
  logic [7:0] slot0_multiplier, slot1_multiplier, slot2_multiplier, control_reg, buffer_control_reg, rx_data;
  logic [1:0] sequence_length_reg;
  logic       select_negated_flag, tx_empty_flag, rx_full_flag, busy, tx_ready, rx_valid;
  logic       serial_clock_pin, serial_clock_oe, slave_select_line_n;
  logic [3:0] io_in, io_out, io_oe;
  logic [2:0] lanes;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;
  logic [1:0] modes [3]  = '{LANE_SINGLE, LANE_DUAL, LANE_QUAD};
  logic [2:0] lns [3]    = '{3'h1, 3'h2, 3'h4};
  logic [7:0] wbytes [3] = '{8'ha1, 8'h4e, 8'hc3};

  qspi_seq_master u_qspi_seq_master (.ref_clk, .nrst, .ctrl_write, .ctrl_wdata, .bfcr_write, .bfcr_wdata,
    .sequence_length_reg, .seq_command_slot0, .seq_command_slot1, .seq_command_slot2, .slot0_multiplier,
    .slot1_multiplier, .slot2_multiplier, .seq_start, .clr_select_negated, .clr_tx_empty, .clr_rx_full,
    .control_reg, .buffer_control_reg, .select_negated_flag, .tx_empty_flag, .rx_full_flag, .busy, .tx_valid,
    .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_ready, .serial_clock_pin, .serial_clock_oe,
    .slave_select_line_n, .io_in, .io_out, .io_oe);
  flash_model u_flash_model (.serial_clock_pin, .slave_select_line_n, .io_out, .io_oe, .io_in, .lanes, .rd_mode);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge ref_clk);
    #5;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] cmd(input logic [3:0] u, input logic k, input logic [1:0] m, input logic d);
    return {u, k, m, d};
  endfunction
  // second tick lets flags that follow the register settle
  task automatic wr_reg(input logic is_bf, input logic [7:0] v);
    ctrl_write = !is_bf;
    bfcr_write = is_bf;
    ctrl_wdata = v;
    bfcr_wdata = v;
    tick;
    ctrl_write = 1'b0;
    bfcr_write = 1'b0;
    tick;
  endtask
  // valid stays up between pushes; the caller lowers it
  task automatic push(input logic [7:0] v);
    tx_valid = 1'b1;
    tx_data = v;
    for (int i = 0; i < 200 && tx_ready !== 1'b1; i++) tick;
    tick;
  endtask
  task automatic pop(output logic [7:0] v);
    rx_ready = 1'b1;
    for (int i = 0; i < 200 && rx_valid !== 1'b1; i++) tick;
    v = rx_data;
    tick;
  endtask
  task automatic clean;
    {clr_select_negated, clr_tx_empty, clr_rx_full} = 3'h7;
    wr_reg(1'b1, 8'hc0);
    {clr_select_negated, clr_tx_empty, clr_rx_full} = 3'h0;
    wr_reg(1'b1, 8'h30);
  endtask
  task automatic run_seq(output int rises);
    logic prev;
    rises = 0;
    seq_start = 1'b1;
    tick;
    seq_start = 1'b0;
    chk("busy", busy, 1'b1);
    for (int i = 0; i < 3000 && busy === 1'b1; i++) begin
      prev = slave_select_line_n;
      tick;
      if (prev === 1'b0 && slave_select_line_n === 1'b1) rises++;
    end
    chk("busy", busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    chk("control_reg", control_reg, CTRL_RESET);
    chk("buffer_control_reg", buffer_control_reg, BFCR_RESET);
    chk("select", slave_select_line_n, 1'b1);
    wr_reg(1'b0, 8'h48);
    chk("control_reg", control_reg, 8'h48);
    chk("serial_clock_oe", serial_clock_oe, 1'b1);
    wr_reg(1'b1, 8'h1d);
    chk("buffer_control_reg", buffer_control_reg, 8'h1d);
  endtask
  task automatic test_fill;
    int n;
    clean;
    push(8'h5a);
    tx_valid = 1'b0;
    clr_tx_empty = 1'b1;
    tick;
    clr_tx_empty = 1'b0;
    tick;
    chk("tx_empty_flag", tx_empty_flag, 1'b0);
    wr_reg(1'b1, 8'h1d);
    chk("tx_empty_flag", tx_empty_flag, 1'b1);
    n = 1;
    tx_valid = 1'b1;
    for (int i = 0; i < 40; i++) begin
      if (tx_ready === 1'b1) n++;
      tick;
    end
    tx_valid = 1'b0;
    chk("tx_fill", 16'(n), 16'(FIFO_DEPTH));
    wr_reg(1'b1, 8'hc0);
    chk("tx_ready", tx_ready, 1'b0);
    wr_reg(1'b1, 8'h30);
    chk("tx_ready", tx_ready, 1'b1);
  endtask
  task automatic test_write(input logic [1:0] mode, input logic [2:0] ln);
    int r;
    clean;
    lanes = ln;
    rd_mode = 1'b0;
    u_flash_model.wr_q.delete();
    for (int i = 0; i < 3; i++) push(wbytes[i]);
    tx_valid = 1'b0;
    sequence_length_reg = 2'h0;
    seq_command_slot0 = cmd(UNIT_8, 1'b0, mode, 1'b0);
    slot0_multiplier = 8'h03;
    run_seq(r);
    chk("wr_count", 16'(u_flash_model.wr_q.size()), 16'h3);
    for (int i = 0; i < 3; i++) chk("wr_byte", u_flash_model.wr_q[i], wbytes[i]);
    chk("select", slave_select_line_n, 1'b1);
    chk("select_negated_flag", select_negated_flag, 1'b1);
    chk("rises", 16'(r), 16'h1);
  endtask
  // the receiver stalls until the whole sequence is over
  task automatic test_read(input logic [1:0] mode, input logic [2:0] ln);
    logic [7:0] v;
    int r;
    clean;
    lanes = ln;
    rd_mode = 1'b1;
    push(8'h00);
    tx_valid = 1'b0;
    sequence_length_reg = 2'h2;
    seq_command_slot0 = cmd(UNIT_32, 1'b1, mode, 1'b1);
    seq_command_slot1 = cmd(UNIT_8, 1'b0, mode, 1'b1);
    seq_command_slot2 = cmd(UNIT_8, 1'b0, LANE_QUAD, 1'b0);
    slot0_multiplier = 8'h04;
    slot1_multiplier = 8'h01;
    slot2_multiplier = 8'h01;
    run_seq(r);
    chk("rises", 16'(r), 16'h2);
    chk("rx_full_flag", rx_full_flag, 1'b1);
    for (int i = 0; i < 17; i++) begin
      pop(v);
      chk("rd_byte", v, 8'(8'h3c + 8'(i) * 8'h11));
    end
    rx_ready = 1'b0;
  endtask
  task automatic test_disable;
    wr_reg(1'b0, 8'h08);
    chk("control_reg", control_reg, 8'h08);
    chk("serial_clock_oe", serial_clock_oe, 1'b1);
    {clr_select_negated, clr_tx_empty, clr_rx_full} = 3'h7;
    sequence_length_reg = SEQ_LEN_RESET;
    seq_start = 1'b1;
    tick;
    {clr_select_negated, clr_tx_empty, clr_rx_full} = 3'h0;
    seq_start = 1'b0;
    tick;
    chk("busy", busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, ctrl_write, bfcr_write, seq_start, tx_valid, rx_ready, rd_mode} = '0;
    {clr_select_negated, clr_tx_empty, clr_rx_full} = '0;
    {ctrl_wdata, bfcr_wdata, tx_data, seq_command_slot0, seq_command_slot1, seq_command_slot2} = '0;
    {slot0_multiplier, slot1_multiplier, slot2_multiplier, sequence_length_reg} = '0;
    lanes = 3'h1;
    repeat (20) @(posedge ref_clk);
    #5;
    nrst = 1'b1;
    tick;
    test_regs;
    test_fill;
    for (int i = 0; i < 3; i++) test_write(modes[i], lns[i]);
    for (int i = 0; i < 3; i++) test_read(modes[i], lns[i]);
    test_disable;
    test_done;
  end
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done;
    end
  end
endmodule
`default_nettype wire
